// ==== src/usb_evt_pkg.sv ====
// ============================================================
// Register map, field layout and reset values
package usb_evt_pkg;
  // Bus geometry
  localparam int ADR_W = 18;
  localparam int DAT_W = 32;
  localparam int IDX_W = 16;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_EVENT_MASK = 16'hfffd;
  localparam logic [15:0] IDX_EVENT_FLAGS = 16'hfffe;
  localparam logic [15:0] IDX_FUNC_ADDR = 16'hffff;
  localparam logic [15:0] IDX_FLAG_CLEAR = 16'hfff0;
  // Event bit positions, shared by flags and mask
  localparam int BIT_SETUP_OVERWRITE = 0;
  localparam int BIT_WAKEUP = 1;
  localparam int BIT_SETUP = 2;
  localparam int BIT_RING_EDGE = 3;
  localparam int BIT_RSV = 4;
  localparam int BIT_RESUME = 5;
  localparam int BIT_SUSPEND = 6;
  localparam int BIT_BUS_RESET = 7;
  // Address field width
  localparam int FA_W = 7;
  // Reset values
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [6:0] RST_FUNC_ADDR = 7'h00;
  // Writable bits of the mask, reserved bit excluded
  localparam logic [7:0] MASK_WRITABLE = 8'hef;
  // Mask bits that the function reset clears
  localparam logic [7:0] MASK_FUNC_RST_CLR = 8'h6f;
  // Read data for an unmapped address
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// ==== src/usb_device_event_status_mask.sv ====
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
// Notes on behaviour
// - A 7-bit function address is held and used as the bus address.
// - Flags are set by hardware and cleared by writing a one or by the function reset.
// - A flag raises the interrupt only while its mask bit is one.
// - Bit 0 sets when a setup packet lands on an unread earlier one.
// - Bit 1 sets on a remote wakeup request from the wakeup pin.
// - Bit 2 sets on a setup; while set, endpoint-zero IN/OUT are NAKed.
// - Bit 3 sets on each rising edge of the ring-indicate input.
// - A ring-indicate event wakes the chip out of suspend.
// - Bit 5 sets when resume signalling is detected.
// - Bit 6 sets on a global or selective suspend condition.
// - Bit 7 sets when the host drives a port reset.
// - Mask bit 7 survives the function reset; of the two resets, only rst clears it.
// - One enable per event, bit 4 reserved read-only, all reset zero.
// - Endpoint-zero IN byte count NAK set means answer IN with NAK.
module usb_device_event_status_mask (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [usb_evt_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [usb_evt_pkg::DAT_W-1:0] wb_dat_i,
  output logic [usb_evt_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Events from the USB engine, one-cycle pulses
  input wire logic setup_rcvd,
  input wire logic resume_seen,
  input wire logic suspend_seen,
  input wire logic bus_reset_seen,
  input wire logic func_rst,
  // Asynchronous pins
  input wire logic wake_pin,
  input wire logic ring_pin,
  // Endpoint-zero buffer states
  input wire logic ep0_in_buf_nak,
  input wire logic ep0_out_buf_nak,
  // Outputs to the engine and core
  output logic [usb_evt_pkg::FA_W-1:0] assigned_bus_address,
  output logic ep0_in_nak_reply,
  output logic ep0_out_nak_reply,
  output logic wake_request,
  output logic irq
);

  // ============================================================
  // Declarations
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] usb_event_enable_mask;
  logic [7:0] usb_event_flags;
  logic [7:0] flags_next;
  logic [6:0] addr_reg;
  logic [7:0] ev;
  logic [7:0] clr;
  logic req, wr_fire;
  logic [15:0] idx;
  logic hit_mask, hit_flags, hit_addr, hit_clear;
  logic wake_s1, wake_s2, wake_s3;
  logic ring_s1, ring_s2, ring_s3;
  logic wake_rise, ring_rise;
  logic in_nak_reg, out_nak_reg, wake_req_reg, irq_reg;

  // ============================================================
  // Bus decode
  // Request qualifier and register index
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[usb_evt_pkg::ADR_W-1:2];
  // Write lands on the edge where the master samples ack
  assign wr_fire = req & wb_we_i & ack_reg & wb_sel_i[0];

  // Address hits
  always_comb begin
    hit_mask = 1'b0;
    hit_flags = 1'b0;
    hit_addr = 1'b0;
    hit_clear = 1'b0;
    if (idx == usb_evt_pkg::IDX_EVENT_MASK) begin
      hit_mask = 1'b1;
    end else if (idx == usb_evt_pkg::IDX_EVENT_FLAGS) begin
      hit_flags = 1'b1;
    end else if (idx == usb_evt_pkg::IDX_FUNC_ADDR) begin
      hit_addr = 1'b1;
    end else if (idx == usb_evt_pkg::IDX_FLAG_CLEAR) begin
      hit_clear = 1'b1;
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read data captured in the request cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= usb_evt_pkg::RD_UNMAPPED;
    end else if (req & ~ack_reg) begin
      if (hit_mask) begin
        rdata_reg <= {24'h00_0000, usb_event_enable_mask};
      end else if (hit_flags) begin
        rdata_reg <= {24'h00_0000, usb_event_flags};
      end else if (hit_addr) begin
        rdata_reg <= {25'h000_0000, addr_reg};
      end else begin
        rdata_reg <= usb_evt_pkg::RD_UNMAPPED;
      end
    end
  end

  assign wb_dat_o = rdata_reg;
  assign wb_ack_o = ack_reg;

  // ============================================================
  // Pin synchronisers and edge detect
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_s1 <= 1'b0;
      wake_s2 <= 1'b0;
      wake_s3 <= 1'b0;
      ring_s1 <= 1'b0;
      ring_s2 <= 1'b0;
      ring_s3 <= 1'b0;
    end else begin
      wake_s1 <= wake_pin;
      wake_s2 <= wake_s1;
      wake_s3 <= wake_s2;
      ring_s1 <= ring_pin;
      ring_s2 <= ring_s1;
      ring_s3 <= ring_s2;
    end
  end

  assign wake_rise = wake_s2 & ~wake_s3;
  assign ring_rise = ring_s2 & ~ring_s3;

  // ============================================================
  // Function address
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= usb_evt_pkg::RST_FUNC_ADDR;
    end else if (func_rst) begin
      addr_reg <= usb_evt_pkg::RST_FUNC_ADDR;
    end else if (wr_fire & hit_addr) begin
      addr_reg <= wb_dat_i[usb_evt_pkg::FA_W-1:0];
    end
  end

  assign assigned_bus_address = addr_reg;

  // ============================================================
  // Event mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_event_enable_mask <= usb_evt_pkg::RST_EVENT_MASK;
    end else if (func_rst) begin
      usb_event_enable_mask <= usb_event_enable_mask &
        ~usb_evt_pkg::MASK_FUNC_RST_CLR;
    end else if (wr_fire & hit_mask) begin
      usb_event_enable_mask <= wb_dat_i[7:0] &
        usb_evt_pkg::MASK_WRITABLE;
    end
  end

  // ============================================================
  // Event flags
  // Hardware events per bit position
  always_comb begin
    ev = 8'h00;
    ev[usb_evt_pkg::BIT_SETUP_OVERWRITE] = setup_rcvd &
      usb_event_flags[usb_evt_pkg::BIT_SETUP];
    ev[usb_evt_pkg::BIT_WAKEUP] = wake_rise;
    ev[usb_evt_pkg::BIT_SETUP] = setup_rcvd;
    ev[usb_evt_pkg::BIT_RING_EDGE] = ring_rise;
    ev[usb_evt_pkg::BIT_RESUME] = resume_seen;
    ev[usb_evt_pkg::BIT_SUSPEND] = suspend_seen;
    ev[usb_evt_pkg::BIT_BUS_RESET] = bus_reset_seen;
  end

  // Clear sources: write-one or function reset
  always_comb begin
    clr = 8'h00;
    if (func_rst) begin
      clr = 8'hff;
    end else if (wr_fire & (hit_flags | hit_clear)) begin
      clr = wb_dat_i[7:0];
    end
  end

  // Per-bit next value, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (gi == usb_evt_pkg::BIT_RSV) begin : g_rsv
        assign flags_next[gi] = 1'b0;
      end else begin : g_evt
        assign flags_next[gi] = ev[gi] |
          (usb_event_flags[gi] & ~clr[gi]);
      end
    end
  endgenerate

  // Flag storage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      usb_event_flags <= usb_evt_pkg::RST_EVENT_FLAGS;
    end else begin
      usb_event_flags <= flags_next;
    end
  end

  // ============================================================
  // Endpoint-zero NAK replies and wake
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_nak_reg <= 1'b1;
      out_nak_reg <= 1'b1;
    end else begin
      in_nak_reg <= ep0_in_buf_nak |
        flags_next[usb_evt_pkg::BIT_SETUP];
      out_nak_reg <= ep0_out_buf_nak |
        flags_next[usb_evt_pkg::BIT_SETUP];
    end
  end

  // Ring edge pulses a wake request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= ring_rise;
    end
  end

  assign ep0_in_nak_reply = in_nak_reg;
  assign ep0_out_nak_reply = out_nak_reg;
  assign wake_request = wake_req_reg;

  // ============================================================
  // Interrupt output
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(usb_event_flags & usb_event_enable_mask);
    end
  end

  assign irq = irq_reg;

  // ============================================================
  // Assertions
  a_addr_load: assert property (@(posedge core_clk) disable iff (rst)
    (wr_fire & hit_addr & ~func_rst) |=>
      assigned_bus_address == $past(wb_dat_i[6:0]))
    else $error("function address not loaded");

  a_zero_keeps: assert property (@(posedge core_clk) disable iff (rst)
    (wr_fire & hit_flags & ~func_rst & ~wb_dat_i[usb_evt_pkg::BIT_RESUME])
      |=> $stable(usb_event_flags[usb_evt_pkg::BIT_RESUME]) ||
        $past(resume_seen))
    else $error("writing zero changed a flag");

  a_one_clears: assert property (@(posedge core_clk) disable iff (rst)
    (wr_fire & (hit_flags | hit_clear) & ~suspend_seen &
      wb_dat_i[usb_evt_pkg::BIT_SUSPEND]) |=>
      ~usb_event_flags[usb_evt_pkg::BIT_SUSPEND])
    else $error("writing one did not clear flag");

  a_irq_gated: assert property (@(posedge core_clk) disable iff (rst)
    ((usb_event_flags & usb_event_enable_mask) == 8'h00) [*2] |-> ~irq)
    else $error("interrupt without enabled flag");

  a_irq_raise: assert property (@(posedge core_clk) disable iff (rst)
    (|(usb_event_flags & usb_event_enable_mask)) |=> irq)
    else $error("enabled flag gave no interrupt");

  a_setup_ovw: assert property (@(posedge core_clk) disable iff (rst)
    (setup_rcvd & usb_event_flags[usb_evt_pkg::BIT_SETUP]) |=>
      usb_event_flags[usb_evt_pkg::BIT_SETUP_OVERWRITE])
    else $error("setup overwrite not flagged");

  a_no_ovw: assert property (@(posedge core_clk) disable iff (rst)
    (setup_rcvd & ~usb_event_flags[usb_evt_pkg::BIT_SETUP] &
      ~usb_event_flags[usb_evt_pkg::BIT_SETUP_OVERWRITE]) |=>
      ~usb_event_flags[usb_evt_pkg::BIT_SETUP_OVERWRITE])
    else $error("overwrite flagged on first setup");

  a_wake_flag: assert property (@(posedge core_clk) disable iff (rst)
    $rose(wake_s2) |=> usb_event_flags[usb_evt_pkg::BIT_WAKEUP])
    else $error("wakeup pin edge not flagged");

  a_setup_nak: assert property (@(posedge core_clk) disable iff (rst)
    setup_rcvd |=> usb_event_flags[usb_evt_pkg::BIT_SETUP] &&
      ep0_in_nak_reply && ep0_out_nak_reply)
    else $error("setup did not force endpoint zero NAK");

  a_ring_flag: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ring_s2) |=> usb_event_flags[usb_evt_pkg::BIT_RING_EDGE])
    else $error("ring edge not flagged");

  a_ring_wake: assert property (@(posedge core_clk) disable iff (rst)
    $rose(ring_s2) |=> wake_request ##1 ~wake_request || $rose(ring_s2))
    else $error("ring edge gave no wake pulse");

  a_bus_events: assert property (@(posedge core_clk) disable iff (rst)
    (resume_seen | suspend_seen | bus_reset_seen) |=>
      (usb_event_flags[usb_evt_pkg::BIT_RESUME] || !$past(resume_seen)) &&
      (usb_event_flags[usb_evt_pkg::BIT_SUSPEND] || !$past(suspend_seen)) &&
      (usb_event_flags[usb_evt_pkg::BIT_BUS_RESET] || !$past(bus_reset_seen)))
    else $error("bus event not flagged");

  a_mask_keep: assert property (@(posedge core_clk) disable iff (rst)
    func_rst |=> $stable(usb_event_enable_mask[usb_evt_pkg::BIT_BUS_RESET])
      && usb_event_enable_mask[6:0] == 7'h00)
    else $error("function reset disturbed reset enable");

  a_mask_rsv: assert property (@(posedge core_clk) disable iff (rst)
    ~usb_event_enable_mask[usb_evt_pkg::BIT_RSV] &&
      ~usb_event_flags[usb_evt_pkg::BIT_RSV])
    else $error("reserved bit set");

  a_in_nak: assert property (@(posedge core_clk) disable iff (rst)
    ep0_in_buf_nak |=> ep0_in_nak_reply)
    else $error("empty IN buffer not NAKed");

endmodule

// ==== test/usb_engine_model.sv ====
`timescale 1ns/10ps
// ============================================================
// USB engine stand-in: turns one-cycle requests into event pulses
module usb_engine_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request bits: bus reset, suspend, resume, setup
  input wire logic [3:0] ev_req,
  // Event pulses towards the block
  output logic setup_rcvd,
  output logic resume_seen,
  output logic suspend_seen,
  output logic bus_reset_seen
);
  // Registered pulses, silent during reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      setup_rcvd <= 1'b0;
      resume_seen <= 1'b0;
      suspend_seen <= 1'b0;
      bus_reset_seen <= 1'b0;
    end else begin
      setup_rcvd <= ev_req[0];
      resume_seen <= ev_req[1];
      suspend_seen <= ev_req[2];
      bus_reset_seen <= ev_req[3];
    end
  end
endmodule

// ==== test/usb_device_event_status_mask_tb_top.sv ====
`timescale 1ns/10ps
// ============================================================
// Testbench top
module usb_device_event_status_mask_tb_top;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [17:0] wb_adr_i = 18'h0_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, wake_request, ep0_in_nak_reply, ep0_out_nak_reply;
  logic setup_rcvd, resume_seen, suspend_seen, bus_reset_seen;
  logic [3:0] ev_req = 4'h0;
  logic func_rst = 1'b0, wake_pin = 1'b0, ring_pin = 1'b0;
  logic ep0_in_buf_nak = 1'b1, ep0_out_buf_nak = 1'b1;
  logic [6:0] assigned_bus_address;
  logic [31:0] q;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int wake_count = 0;

  // Clock at 40 MHz
  always #12.5 core_clk = ~core_clk;

  usb_engine_model engine (.core_clk(core_clk), .rst(rst), .ev_req(ev_req),
    .setup_rcvd(setup_rcvd), .resume_seen(resume_seen),
    .suspend_seen(suspend_seen), .bus_reset_seen(bus_reset_seen));

  usb_device_event_status_mask dut (.core_clk(core_clk), .rst(rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .setup_rcvd(setup_rcvd),
    .resume_seen(resume_seen), .suspend_seen(suspend_seen),
    .bus_reset_seen(bus_reset_seen), .func_rst(func_rst),
    .wake_pin(wake_pin), .ring_pin(ring_pin),
    .ep0_in_buf_nak(ep0_in_buf_nak), .ep0_out_buf_nak(ep0_out_buf_nak),
    .assigned_bus_address(assigned_bus_address),
    .ep0_in_nak_reply(ep0_in_nak_reply),
    .ep0_out_nak_reply(ep0_out_nak_reply),
    .wake_request(wake_request), .irq(irq));

  // Cycle ceiling and wake pulse counter
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wake_request === 1'b1) wake_count <= wake_count + 1;
    if (cycles == 4000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; data taken at the ack edge
  task automatic wb(input logic we, input logic [15:0] idx,
                    input logic [7:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Read a register and compare its value
  task automatic rd(input string nm, input logic [15:0] idx,
                    input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(nm, q, {24'h00_0000, exp});
  endtask

  // One engine event, then let it settle
  task automatic ev(input logic [3:0] c);
    @(posedge core_clk);
    ev_req <= c;
    @(posedge core_clk);
    ev_req <= 4'h0;
    repeat (3) @(posedge core_clk);
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rd("mask", usb_evt_pkg::IDX_EVENT_MASK, 8'h00);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'h00);
    rd("addr", usb_evt_pkg::IDX_FUNC_ADDR, 8'h00);
    wb(1'b1, usb_evt_pkg::IDX_FUNC_ADDR, 8'hff);
    rd("addr", usb_evt_pkg::IDX_FUNC_ADDR, 8'h7f);
    chk("bus_addr", 32'(assigned_bus_address), 32'h0000_007f);
    wb(1'b1, usb_evt_pkg::IDX_EVENT_MASK, 8'hff);
    rd("mask", usb_evt_pkg::IDX_EVENT_MASK, 8'hef);
    ep0_in_buf_nak <= 1'b0;
    ep0_out_buf_nak <= 1'b0;
    ev(4'h1);
    chk("in_nak", 32'(ep0_in_nak_reply), 32'h0000_0001);
    chk("out_nak", 32'(ep0_out_nak_reply), 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0001);
    ev(4'h1);
    ev(4'h2);
    ev(4'h4);
    ev(4'h8);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'he5);
    wb(1'b1, usb_evt_pkg::IDX_EVENT_FLAGS, 8'h00);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'he5);
    wb(1'b1, usb_evt_pkg::IDX_EVENT_MASK, 8'h00);
    repeat (3) @(posedge core_clk);
    chk("irq", 32'(irq), 32'h0000_0000);
    wb(1'b1, usb_evt_pkg::IDX_EVENT_FLAGS, 8'h04);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'he1);
    chk("in_nak", 32'(ep0_in_nak_reply), 32'h0000_0000);
    ep0_in_buf_nak <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("in_nak", 32'(ep0_in_nak_reply), 32'h0000_0001);
    wb(1'b1, usb_evt_pkg::IDX_FLAG_CLEAR, 8'he1);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'h00);
    rd("clear", usb_evt_pkg::IDX_FLAG_CLEAR, 8'h00);
    wake_pin <= 1'b1;
    ring_pin <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'h0a);
    chk("wake_count", 32'(wake_count), 32'h0000_0001);
    chk("irq", 32'(irq), 32'h0000_0000);
    wb(1'b1, usb_evt_pkg::IDX_EVENT_MASK, 8'h08);
    repeat (3) @(posedge core_clk);
    chk("irq", 32'(irq), 32'h0000_0001);
    wb(1'b1, usb_evt_pkg::IDX_EVENT_MASK, 8'hff);
    @(posedge core_clk);
    func_rst <= 1'b1;
    @(posedge core_clk);
    func_rst <= 1'b0;
    rd("mask", usb_evt_pkg::IDX_EVENT_MASK, 8'h80);
    rd("addr", usb_evt_pkg::IDX_FUNC_ADDR, 8'h00);
    rd("flags", usb_evt_pkg::IDX_EVENT_FLAGS, 8'h00);
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    rd("mask", usb_evt_pkg::IDX_EVENT_MASK, 8'h00);
    rd("unmapped", 16'h0000, 8'h00);
    end_sim();
  end
endmodule
